// ---- inc/scl_pkg.sv ----
// Constants and types shared by the serial console front end
package scl_pkg;
  localparam longint unsigned CLK_HZ = 10_000_000;
  localparam longint unsigned BAUD_DEF = 9600;
  localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_DEF);
  localparam logic [15:0] BAUD_DIV_MIN = 16'h0004;
  // Time between readings, in milliseconds
  localparam longint unsigned T_SLOW_MS = 400;
  localparam longint unsigned T_MED_MS = 50;
  localparam longint unsigned T_FAST_MS = 10;
  localparam longint unsigned T_FREQ_MS = 250;
  localparam int RD_SLOW_CYC = int'(T_SLOW_MS * CLK_HZ / 1000);
  localparam int RD_MED_CYC = int'(T_MED_MS * CLK_HZ / 1000);
  localparam int RD_FAST_CYC = int'(T_FAST_MS * CLK_HZ / 1000);
  localparam int RD_FREQ_CYC = int'(T_FREQ_MS * CLK_HZ / 1000);
  localparam int LINE_DEPTH = 50;
  localparam int FRAME_W = 12;
  // Register byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_BAUD = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_IDX = 8'h0c;
  localparam logic [7:0] A_LDATA = 8'h10;
  localparam logic [7:0] A_RESP = 8'h14;
  localparam logic [7:0] A_DONE = 8'h18;
  // Status bit positions
  localparam int ST_READY = 0;
  localparam int ST_ERR = 1;
  localparam int ST_CLR = 2;
  localparam int ST_PRINT = 3;
  localparam int ST_TXFULL = 4;
  localparam int ST_PBUSY = 5;
  localparam int ST_TWO = 6;
  localparam int ST_LEN = 8;
  localparam int RESP_EOL = 8;
  // Characters
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_BS = 8'h08;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_GT = 8'h3e;
  localparam logic [7:0] CH_OK = 8'h3d;
  localparam logic [7:0] CH_CERR = 8'h3f;
  localparam logic [7:0] CH_XERR_DEF = 8'h21;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] MR_SLOW = 2'h0;
  localparam logic [1:0] MR_MED = 2'h1;
  localparam logic [1:0] FC_FREQ = 2'h1;
  localparam logic [1:0] FC_DIODE = 2'h2;
  localparam logic [1:0] RES_OK = 2'h0;
  localparam logic [1:0] RES_CERR = 2'h1;
  typedef struct packed {
    logic dual;
    logic [1:0] fclass;
    logic [1:0] mrate;
    logic [3:0] prate;
    logic [1:0] parity;
    logic data8;
    logic echo;
  } scl_cfg_t;
  localparam scl_cfg_t CFG_RST = '{dual: 1'b0, fclass: 2'h0, mrate: MR_SLOW,
    prate: 4'h0, parity: PAR_NONE, data8: 1'b1, echo: 1'b0};
endpackage : scl_pkg

// ---- verilog/scl_console.sv ----
// Serial console front end: UART, line editor, prompts, print-only pacing
//
// Contract
// [RULE1] Reset config: 9600 baud, 8 data bits, one stop, no parity, echo off.
// [RULE2] Word length selectable as 7 or 8 data bits; host must match.
// [RULE3] Link settings change only by panel writes, never by serial input.
// [RULE4] With echo on, echo every received character and prompt after commands. Characters with a parity or framing error are not echoed.
// [RULE5] With echo off, no echo and no command prompts.
// [RULE6] Backspace removes the last buffered character of the pending line.
// [RULE7] Backspace itself is echoed only when echo is on.
// [RULE8] Control-C clears the device and sends success prompt plus CR LF.
// [RULE9] Prompt follows command execution and any response text.
// [RULE10] Successful command gets the success prompt.
// [RULE11] Command not understood gets the command-error prompt.
// [RULE12] Command understood but not executable gets execution-error prompt.
// [RULE13] Execution-error prompt is configurable char plus greater-than sign.
// [RULE14] Print-only mode prints every N-th completed reading.
// [RULE15] N follows 1-2-5 steps from 1 up to 50000.
// [RULE16] Print rate zero disables print-only output; it is the default.
// [RULE17] Print line holds one or two measurements, following dual display.
// [RULE18] Readings come at 2.5, 20 or 100 per second by rate.
// [RULE19] Frequency uses four readings per second; diode and continuity fast.
// [RULE20] Commands stay accepted while print-only output runs.
// [RULE21] Received characters held in a fifty byte line buffer.
// [RULE22] Line ends on CR, LF or CR LF.
// [RULE23] Parity or framing error flags an error and discards the line.
// [RULE24] Response lines end with CR LF.
`timescale 1ns/1ps
module scl_console #(
  parameter int RD_SLOW_CYC = scl_pkg::RD_SLOW_CYC,
  parameter int RD_MED_CYC = scl_pkg::RD_MED_CYC,
  parameter int RD_FAST_CYC = scl_pkg::RD_FAST_CYC,
  parameter int RD_FREQ_CYC = scl_pkg::RD_FREQ_CYC,
  parameter logic [7:0] CH_XERR = scl_pkg::CH_XERR_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  input wire logic reading_done,
  output logic reading_tick,
  output logic print_pulse,
  output logic dev_clear
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (CH_XERR == scl_pkg::CH_OK || CH_XERR == scl_pkg::CH_CERR) begin : g_bad_xerr
    $error("execution error prompt char must differ from the others");
  end
  if (RD_FAST_CYC < 2 || RD_MED_CYC < 2 || RD_SLOW_CYC < 2 || RD_FREQ_CYC < 2) begin : g_bad_cad
    $error("reading cadence counts must be at least two");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  typedef enum {RX_IDLE, RX_RUN} scl_rx_t;
  scl_rx_t rx_st;
  scl_pkg::scl_cfg_t cfg;
  logic [15:0] baud_div;
  logic [7:0] line_buf [scl_pkg::LINE_DEPTH];
  logic [5:0] len, rd_idx;
  logic ready, err, clr_flag, print_flag, two, last_cr;
  logic rx_s1, rx_s2, rx_done;
  logic [15:0] rx_cnt, tx_cnt;
  logic [3:0] rx_idx, tx_left;
  logic [scl_pkg::FRAME_W-1:0] rx_frame, tx_sh;
  logic tx_busy, echo_pend, resp_pend, resp_eol, eol_pend, prompt_pend, seq_act;
  logic [7:0] echo_ch, resp_ch, pchar;
  logic [1:0] step;
  logic [31:0] cad_cnt, cad_len;
  logic [16:0] prn_cnt, prn_n;
  logic [31:0] rd_val, stat;
  logic prn_on, prn_hit;

  ////////////////////////////////////////////////////////////////////////
  // APB decode

  wire setup = psel && !penable;
  wire acc = psel && penable && pclk_en;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == scl_pkg::A_CTRL;
  wire hit_baud = paddr == scl_pkg::A_BAUD;
  wire hit_stat = paddr == scl_pkg::A_STAT;
  wire hit_idx = paddr == scl_pkg::A_IDX;
  wire hit_ldata = paddr == scl_pkg::A_LDATA;
  wire hit_resp = paddr == scl_pkg::A_RESP;
  wire hit_done = paddr == scl_pkg::A_DONE;
  wire mapped = hit_ctrl | hit_baud | hit_stat | hit_idx | hit_ldata | hit_resp | hit_done;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_baud = wr && hit_baud && pwdata[15:0] >= scl_pkg::BAUD_DIV_MIN;
  wire wr_stat = wr && hit_stat;
  wire wr_resp = wr && hit_resp;
  wire wr_done = wr && hit_done;
  wire [1:0] result = pwdata[1:0];

  assign pready = pclk_en;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    stat = '0;
    stat[scl_pkg::ST_READY] = ready;
    stat[scl_pkg::ST_ERR] = err;
    stat[scl_pkg::ST_CLR] = clr_flag;
    stat[scl_pkg::ST_PRINT] = print_flag;
    stat[scl_pkg::ST_TXFULL] = resp_pend;
    stat[scl_pkg::ST_PBUSY] = prompt_pend | seq_act | eol_pend;
    stat[scl_pkg::ST_TWO] = two;
    stat[scl_pkg::ST_LEN +: 6] = len;
  end

  assign rd_val = hit_ctrl ? 32'(cfg) :
                  hit_baud ? {16'h0000, baud_div} :
                  hit_stat ? stat :
                  hit_idx ? {26'h0, rd_idx} :
                  hit_ldata && rd_idx < 6'(scl_pkg::LINE_DEPTH) ? {24'h0, line_buf[rd_idx]} :
                  32'h0000_0000;

  // Read data is caught in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (pclk_en && setup) begin
      prdata <= rd_val;
    end
  end

  // Only the bus writes these; nothing on the serial path reaches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= scl_pkg::CFG_RST; // RULE1 RULE16
      baud_div <= scl_pkg::BAUD_DIV_RST; // RULE1
      rd_idx <= '0;
    end else if (pclk_en) begin
      if (wr_ctrl) cfg <= scl_pkg::scl_cfg_t'(pwdata[12:0]); // RULE3
      if (wr_baud) baud_div <= pwdata[15:0]; // RULE3
      if (wr && hit_idx) rd_idx <= pwdata[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame geometry

  wire [3:0] n_data = cfg.data8 ? 4'd8 : 4'd7; // RULE2
  wire has_par = cfg.parity != scl_pkg::PAR_NONE;
  wire [3:0] n_bits = 4'd2 + n_data + {3'b000, has_par};

  function automatic logic par_of(input logic [7:0] d, input logic [1:0] p, input logic w8);
    logic x;
    x = w8 ? ^d : ^d[6:0];
    return (p == scl_pkg::PAR_ODD) ? ~x : x;
  endfunction : par_of

  ////////////////////////////////////////////////////////////////////////
  // Receiver

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else if (pclk_en) begin
      rx_s1 <= rxd;
      rx_s2 <= rx_s1;
    end
  end

  wire rx_tick = rx_st == RX_RUN && rx_cnt == '0;
  wire rx_last = rx_tick && rx_idx == n_bits - 4'd1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st <= RX_IDLE;
      rx_cnt <= '0;
      rx_idx <= '0;
      rx_frame <= '0;
      rx_done <= 1'b0;
    end else if (pclk_en) begin
      rx_done <= rx_last;
      case (rx_st)
        RX_IDLE: begin
          if (!rx_s2) begin
            rx_st <= RX_RUN;
            rx_cnt <= baud_div >> 1;
            rx_idx <= '0;
          end
        end
        RX_RUN: begin
          if (rx_tick) begin
            rx_frame[rx_idx] <= rx_s2;
            rx_cnt <= baud_div - 16'd1;
            rx_idx <= rx_idx + 4'd1;
            if (rx_last || (rx_idx == '0 && rx_s2)) rx_st <= RX_IDLE;
          end else begin
            rx_cnt <= rx_cnt - 16'd1;
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  wire [7:0] rx_ch = cfg.data8 ? rx_frame[8:1] : {1'b0, rx_frame[7:1]};
  wire par_bad = has_par && rx_frame[n_data + 4'd1] != par_of(rx_ch, cfg.parity, cfg.data8);
  wire frm_bad = !rx_frame[n_bits - 4'd1];
  wire got = rx_done && pclk_en;
  wire got_bad = got && (par_bad || frm_bad);
  wire got_ok = got && !par_bad && !frm_bad;
  wire is_etx = rx_ch == scl_pkg::CH_ETX;
  wire is_bs = rx_ch == scl_pkg::CH_BS;
  wire is_cr = rx_ch == scl_pkg::CH_CR;
  wire is_lf = rx_ch == scl_pkg::CH_LF;
  wire swallow_lf = got_ok && is_lf && last_cr;
  wire busy_line = got_ok && !is_etx && !swallow_lf && ready;
  wire full_line = got_ok && !is_etx && !is_bs && !is_cr && !is_lf && !ready
                   && len == 6'(scl_pkg::LINE_DEPTH);
  wire store = got_ok && !is_etx && !is_bs && !is_cr && !is_lf && !ready && !full_line;
  wire term = got_ok && !ready && (is_cr || (is_lf && !last_cr));
  wire set_err = got_bad || busy_line || full_line;

  ////////////////////////////////////////////////////////////////////////
  // Line buffer and editing

  for (genvar i = 0; i < scl_pkg::LINE_DEPTH; i++) begin : g_line
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        line_buf[i] <= '0;
      end else if (store && len == 6'(i)) begin
        line_buf[i] <= rx_ch; // RULE21
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len <= '0;
      ready <= 1'b0;
      last_cr <= 1'b0;
    end else if (pclk_en) begin
      if (got) last_cr <= got_ok && is_cr;
      if (got_ok && is_etx) begin
        len <= '0; // RULE8
        ready <= 1'b0;
      end else if (got_bad || full_line) begin
        if (!ready) len <= '0; // RULE23
      end else if (wr_done) begin
        len <= '0;
        ready <= 1'b0;
      end else if (term) begin
        ready <= 1'b1; // RULE22
      end else if (got_ok && is_bs && !ready && len != '0) begin
        len <= len - 6'd1; // RULE6
      end else if (store) begin
        len <= len + 6'd1; // RULE21
      end
    end
  end

  // Sticky flags: a new event in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= 1'b0;
      clr_flag <= 1'b0;
      print_flag <= 1'b0;
      dev_clear <= 1'b0;
    end else if (pclk_en) begin
      err <= (err && !(wr_stat && pwdata[scl_pkg::ST_ERR])) || set_err; // RULE23
      clr_flag <= (clr_flag && !(wr_stat && pwdata[scl_pkg::ST_CLR])) || (got_ok && is_etx);
      print_flag <= (print_flag && !(wr_stat && pwdata[scl_pkg::ST_PRINT])) || prn_hit;
      dev_clear <= got_ok && is_etx; // RULE8
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit arbitration: echo, then prompt or CR LF tail, then response

  wire src_echo = echo_pend;
  wire src_seq = !echo_pend && seq_act;
  wire src_resp = !echo_pend && !seq_act && resp_pend;
  wire tx_go = pclk_en && !tx_busy && (src_echo || src_seq || src_resp);
  wire seq_launch = pclk_en && !seq_act && !resp_pend && (eol_pend || prompt_pend);
  wire [7:0] seq_ch = step == 2'd0 ? pchar :
                      step == 2'd1 ? scl_pkg::CH_GT :
                      step == 2'd2 ? scl_pkg::CH_CR : scl_pkg::CH_LF;
  wire [7:0] tx_ch = src_echo ? echo_ch : src_seq ? seq_ch : resp_ch;
  wire [7:0] res_ch = result == scl_pkg::RES_OK ? scl_pkg::CH_OK :
                      result == scl_pkg::RES_CERR ? scl_pkg::CH_CERR : CH_XERR;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      echo_pend <= 1'b0;
      echo_ch <= '0;
    end else if (pclk_en) begin
      if (got_ok && cfg.echo) begin
        echo_pend <= 1'b1; // RULE4 RULE7 RULE20
        echo_ch <= rx_ch;
      end else if (tx_go && src_echo) begin
        echo_pend <= 1'b0; // RULE5
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_pend <= 1'b0;
      resp_eol <= 1'b0;
      resp_ch <= '0;
      eol_pend <= 1'b0;
      prompt_pend <= 1'b0;
      pchar <= scl_pkg::CH_OK;
      seq_act <= 1'b0;
      step <= '0;
    end else if (pclk_en) begin
      if (wr_resp && !resp_pend) begin
        resp_pend <= 1'b1;
        resp_ch <= pwdata[7:0];
        resp_eol <= pwdata[scl_pkg::RESP_EOL];
      end else if (tx_go && src_resp) begin
        resp_pend <= 1'b0;
        if (resp_eol) eol_pend <= 1'b1; // RULE24
      end
      if (got_ok && is_etx) begin
        prompt_pend <= 1'b1; // RULE8
        pchar <= scl_pkg::CH_OK;
      end else if (wr_done && cfg.echo) begin
        prompt_pend <= 1'b1; // RULE9 RULE4
        pchar <= res_ch; // RULE10 RULE11 RULE12 RULE13
      end
      if (seq_launch) begin
        seq_act <= 1'b1;
        if (eol_pend) begin
          step <= 2'd2; // RULE24
          eol_pend <= 1'b0;
        end else begin
          step <= 2'd0; // RULE9
          if (!(got_ok && is_etx) && !(wr_done && cfg.echo)) prompt_pend <= 1'b0;
        end
      end else if (tx_go && src_seq) begin
        if (step == 2'd3) seq_act <= 1'b0;
        step <= step + 2'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmitter

  function automatic logic [scl_pkg::FRAME_W-1:0] frame_of(input logic [7:0] d);
    logic [scl_pkg::FRAME_W-1:0] f;
    f = '1;
    f[0] = 1'b0;
    for (int b = 0; b < 8; b++) begin
      if (b < int'(n_data)) f[b + 1] = d[b];
    end
    if (has_par) f[n_data + 4'd1] = par_of(d, cfg.parity, cfg.data8);
    return f;
  endfunction : frame_of

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy <= 1'b0;
      tx_sh <= '1;
      tx_left <= '0;
      tx_cnt <= '0;
    end else if (pclk_en) begin
      if (tx_go) begin
        tx_busy <= 1'b1;
        tx_sh <= frame_of(tx_ch); // RULE2
        tx_left <= n_bits;
        tx_cnt <= baud_div - 16'd1;
      end else if (tx_busy) begin
        if (tx_cnt == '0) begin
          tx_sh <= {1'b1, tx_sh[scl_pkg::FRAME_W-1:1]};
          tx_left <= tx_left - 4'd1;
          tx_cnt <= baud_div - 16'd1;
          if (tx_left == 4'd1) tx_busy <= 1'b0;
        end else begin
          tx_cnt <= tx_cnt - 16'd1;
        end
      end
    end
  end

  assign txd = tx_sh[0];

  ////////////////////////////////////////////////////////////////////////
  // Reading cadence and print-only pacing

  assign cad_len = cfg.fclass == scl_pkg::FC_FREQ ? 32'(RD_FREQ_CYC) : // RULE19
                   cfg.fclass == scl_pkg::FC_DIODE ? 32'(RD_FAST_CYC) :
                   cfg.mrate == scl_pkg::MR_SLOW ? 32'(RD_SLOW_CYC) : // RULE18
                   cfg.mrate == scl_pkg::MR_MED ? 32'(RD_MED_CYC) : 32'(RD_FAST_CYC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cad_cnt <= '0;
      reading_tick <= 1'b0;
    end else if (pclk_en) begin
      reading_tick <= cad_cnt >= cad_len - 32'd1;
      cad_cnt <= (cad_cnt >= cad_len - 32'd1) ? '0 : cad_cnt + 32'd1; // RULE18
    end
  end

  always_comb begin
    case (cfg.prate) // RULE15
      4'h1: prn_n = 17'd1;
      4'h2: prn_n = 17'd2;
      4'h3: prn_n = 17'd5;
      4'h4: prn_n = 17'd10;
      4'h5: prn_n = 17'd20;
      4'h6: prn_n = 17'd50;
      4'h7: prn_n = 17'd100;
      4'h8: prn_n = 17'd200;
      4'h9: prn_n = 17'd500;
      4'ha: prn_n = 17'd1000;
      4'hb: prn_n = 17'd2000;
      4'hc: prn_n = 17'd5000;
      4'hd: prn_n = 17'd10000;
      4'he: prn_n = 17'd20000;
      4'hf: prn_n = 17'd50000;
      default: prn_n = 17'd0;
    endcase
  end

  assign prn_on = cfg.prate != 4'h0; // RULE16
  assign prn_hit = pclk_en && reading_done && prn_on && prn_cnt + 17'd1 >= prn_n;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prn_cnt <= '0;
      print_pulse <= 1'b0;
      two <= 1'b0;
    end else if (pclk_en) begin
      print_pulse <= prn_hit; // RULE14
      if (!prn_on || prn_hit) prn_cnt <= '0;
      else if (reading_done) prn_cnt <= prn_cnt + 17'd1;
      if (prn_hit) two <= cfg.dual; // RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_seq_start;
    pclk_en && seq_launch && !eol_pend;
  endsequence
  sequence s_tail_lf;
    tx_go && src_seq && step == 2'd3;
  endsequence

  chk_cfg_bus_only: assert property ($changed(cfg) |-> $past(wr_ctrl)) // RULE3
    else $error("config changed without a control write");
  chk_echo_on_char: assert property (got_ok && cfg.echo |=> echo_pend && echo_ch == $past(rx_ch)) // RULE4
    else $error("received char not queued for echo");
  chk_echo_off_quiet: assert property ($rose(echo_pend) |-> $past(cfg.echo)) // RULE5
    else $error("echo queued while echo off");
  chk_bs_shrink: assert property (got_ok && is_bs && !ready && len != '0 |=> len == $past(len) - 6'd1) // RULE6
    else $error("backspace did not remove a char");
  chk_etx_prompt: assert property (got_ok && is_etx |=> prompt_pend && pchar == scl_pkg::CH_OK && len == '0) // RULE8
    else $error("control-C did not clear and prompt");
  chk_prompt_order: assert property (s_seq_start |-> !resp_pend ##1 (seq_act && step == 2'd0)) // RULE9
    else $error("prompt started before response drained");
  chk_tail_end: assert property (s_tail_lf |-> tx_ch == scl_pkg::CH_LF ##1 !seq_act) // RULE24
    else $error("CR LF tail did not finish with LF");
  chk_print_nth: assert property (print_pulse |-> $past(reading_done) && $past(prn_cnt) == $past(prn_n) - 17'd1) // RULE14
    else $error("print not on the N-th reading");
  chk_print_off: assert property (cfg.prate == 4'h0 |=> !print_pulse) // RULE16
    else $error("print output while print rate zero");
  chk_rx_err_drop: assert property (got_bad && !ready |=> err && len == '0) // RULE23
    else $error("bad character did not discard the line");

endmodule : scl_console

// ---- verification/scl_host.sv ----
// Host side serial model: sends characters to the device and collects its output
`timescale 1ns/1ps
module scl_host (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  int bit_div = 16;
  logic [7:0] rx_q[$];
  logic [7:0] sh;
  // Idle mark level between frames
  initial rxd = 1'b1;
  // Start bit, eight data bits first bit lowest, one stop bit
  task automatic send_char(input logic [7:0] c);
    logic [9:0] fr;
    fr = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (bit_div) @(posedge clk);
    end
  endtask : send_char
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_char(s[i]);
    end
  endtask : send_str
  // Receiver samples mid-bit and keeps every character the device sends
  always begin
    @(negedge txd);
    repeat (bit_div / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_div) @(posedge clk);
      sh[i] = txd;
    end
    repeat (bit_div) @(posedge clk);
    rx_q.push_back(sh);
  end
endmodule : scl_host

// ---- verification/scl_console_tb.sv ----
// Self-checking bench for the serial console front end
`timescale 1ns/1ps
module scl_console_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic reading_done = 1'b0;
  logic [31:0] prdata, q;
  logic se;
  logic pready, pslverr, rxd, txd, reading_tick, print_pulse, dev_clear;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_print = 0;
  int n_clr = 0;
  int n_tick = 0;
  string pr;
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
  always #50 pclk = ~pclk;
  scl_console #(.RD_SLOW_CYC(40), .RD_MED_CYC(20), .RD_FAST_CYC(10), .RD_FREQ_CYC(25)) i_dut (
    .pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .txd(txd), .reading_done(reading_done),
    .reading_tick(reading_tick), .print_pulse(print_pulse), .dev_clear(dev_clear));
  scl_host i_host (.clk(pclk), .txd(txd), .rxd(rxd));
  always @(negedge pclk) begin
    cyc++;
    if (print_pulse === 1'b1) n_print++;
    if (dev_clear === 1'b1) n_clr++;
    if (reading_tick === 1'b1) n_tick++;
    if (cyc == 60000) begin
      err_total++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Waits for the whole string, then compares it and checks nothing extra came
  task automatic expect_str(input string s);
    int n;
    n = 0;
    while (i_host.rx_q.size() < s.len() && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    repeat (400) @(posedge pclk);
    `CHK("tx count", s.len(), i_host.rx_q.size())
    for (int i = 0; i < s.len() && i_host.rx_q.size() > 0; i++) begin
      `CHK("tx char", s[i], i_host.rx_q.pop_front())
    end
    i_host.rx_q.delete();
  endtask : expect_str
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, scl_pkg::A_CTRL, 32'h0);
    `CHK("ctrl", 32'h2, q)
    apb(1'b0, scl_pkg::A_BAUD, 32'h0);
    `CHK("baud", 32'd1041, q)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, q)
    `CHK("slverr", 1'b1, se)
    apb(1'b1, scl_pkg::A_BAUD, 32'd16);
    $display("test reset done");
    i_host.send_str("A\015");
    expect_str("");
    apb(1'b0, scl_pkg::A_STAT, 32'h0);
    `CHK("stat", 32'h101, q & 32'h3f01)
    apb(1'b1, scl_pkg::A_IDX, 32'h0);
    apb(1'b0, scl_pkg::A_LDATA, 32'h0);
    `CHK("ldata", 32'h41, q)
    apb(1'b1, scl_pkg::A_DONE, 32'h0);
    expect_str("");
    apb(1'b0, scl_pkg::A_CTRL, 32'h0);
    `CHK("ctrl kept", 32'h2, q)
    $display("test echo off done");
    apb(1'b1, scl_pkg::A_CTRL, 32'h3);
    i_host.send_str("AB\010\012");
    expect_str("AB\010\012");
    apb(1'b0, scl_pkg::A_STAT, 32'h0);
    `CHK("bs len", 32'h101, q & 32'h3f01)
    apb(1'b1, scl_pkg::A_DONE, 32'h0);
    expect_str("=>\015\012");
    for (int r = 0; r < 3; r++) begin
      i_host.send_str("B\015");
      expect_str("B\015");
      apb(1'b1, scl_pkg::A_RESP, 32'h178);
      apb(1'b1, scl_pkg::A_DONE, r);
      pr = (r == 0) ? "=" : (r == 1) ? "?" : "!";
      expect_str({"x\015\012", pr, ">\015\012"});
    end
    $display("test echo on done");
    apb(1'b1, scl_pkg::A_CTRL, 32'h2);
    i_host.send_char(scl_pkg::CH_ETX);
    expect_str("=>\015\012");
    `CHK("clear", 1, n_clr)
    $display("test clear done");
    apb(1'b1, scl_pkg::A_CTRL, 32'h5);
    i_host.send_char(8'hc1);
    expect_str("\301");
    i_host.send_char(8'h41);
    expect_str("");
    apb(1'b0, scl_pkg::A_STAT, 32'h0);
    `CHK("par err", 32'h2, q & 32'h3f03)
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, scl_pkg::A_CTRL, c == 0 ? 32'h2 : c == 1 ? 32'h102 : c == 2 ? 32'h402 : 32'h802);
      repeat (50) @(posedge pclk);
      n_tick = 0;
      repeat (200) @(posedge pclk);
      `CHK("cadence", c == 0 ? 5 : c == 1 ? 10 : c == 2 ? 8 : 20, n_tick)
    end
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, scl_pkg::A_CTRL, m ? 32'h1232 : 32'h1202);
      n_print = 0;
      n_tick = 0;
      for (int k = 0; k < 10; k++) begin
        reading_done <= 1'b1;
        @(posedge pclk);
        reading_done <= 1'b0;
        repeat (9) @(posedge pclk);
      end
      `CHK("prints", m ? 2 : 0, n_print)
      `CHK("ticks", 10, n_tick)
    end
    apb(1'b0, scl_pkg::A_STAT, 32'h0);
    `CHK("dual", 32'h48, q & 32'h48)
    $display("test print done");
    wrap_up();
  end
endmodule : scl_console_tb
